/* logic/serial_switch_pkg.sv */
// constants shared by the serial switch control interface
// assumes a 125 MHz system clock and a shift clock of its own
package serial_switch_pkg;

   // ***********************************************************
   // frame layout
   // ***********************************************************
   localparam int WORD_W        = 24;   // bits per command or status word
   localparam int OUT_N         = 16;   // number of switched outputs
   localparam int ANY_FAULT_BIT = 23;   // status: any fault
   localparam int OV_BIT        = 22;   // status: overvoltage
   localparam int ZERO_LSB      = 16;   // status: lowest always-zero bit
   localparam int ZERO_W        = 6;    // status: always-zero bits
   localparam int CMD_LSB       = 18;   // command field position
   localparam int CMD_W         = 6;    // command field width
   localparam logic [CMD_W-1:0] CMD_ONOFF = 6'h00;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [WORD_W-1:0] WORD_RST = 24'h00_0000;
   localparam logic [OUT_N-1:0]  OUT_RST  = 16'h0000;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_MHZ      = 125;
   localparam int DLY_MIN_NS   = 1000;   // earliest output response
   localparam int DLY_MAX_NS   = 50000;  // latest output response
   localparam int DLY_APPLY_NS = 15000;  // chosen response time
   localparam int DLY_MIN_CYC  = (DLY_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int DLY_APPLY_CYC = (DLY_APPLY_NS * CLK_MHZ) / 1000;
   localparam int DLY_MAX_CYC_DEF = (DLY_MAX_NS * CLK_MHZ) / 1000;
   localparam int DLY_W        = 11;     // holds DLY_APPLY_CYC
   localparam int SINCE_W      = 13;     // helper count, above max delay
   localparam int FLT_MIN_US   = 100;    // shortest fault persistence
   localparam int FLT_MAX_US   = 450;    // longest fault persistence
   localparam int FLT_CYC_DEF  = FLT_MIN_US * CLK_MHZ;
   localparam int FLT_W        = 16;     // holds up to FLT_MAX_US

   // ***********************************************************
   // output apply sequencer, gray coded except the AP_LOAD to AP_IDLE step
   // ***********************************************************
   typedef enum logic [1:0] {
      AP_IDLE = 2'h0,
      AP_WAIT = 2'h1,
      AP_LOAD = 2'h3
   } apply_e;

endpackage : serial_switch_pkg

/* logic/switch_spi_link.sv */
// shift-clock side of the serial switch interface
// assumes shift clock idles low; clock pulses while deselected are ignored
`timescale 1ns/1ps
module switch_spi_link
   import serial_switch_pkg::*;
(
   input  wire logic              sclk,
   input  wire logic              rst_n,
   input  wire logic              cs_n,
   input  wire logic              si,
   input  wire logic [WORD_W-1:0] status_word,
   output logic                   so_bit,
   output logic [WORD_W-1:0]      rx_word
);

   // ***********************************************************
   // frame state
   // ***********************************************************
   logic              link_rst_n;
   logic [WORD_W-1:0] shift_ff;
   logic [WORD_W-1:0] nxt_shift;
   logic              first_fall_ff;
   logic              first_rise_ff;
   logic              so_ff;

   // frame flags restart whenever the device is deselected
   assign link_rst_n = rst_n & ~cs_n;

   // first falling edge takes the status tail, later ones shift the register
   always_comb begin
      if (first_fall_ff) begin
         nxt_shift = {status_word[WORD_W-2:0], si};  // [R05]
      end else begin
         nxt_shift = {shift_ff[WORD_W-2:0], si};     // [R01] [R19]
      end
   end

   // input register holds the last 24 bits seen  [R20] [R22]
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_ff <= WORD_RST;
      end else if (!cs_n) begin                      // [R03]
         shift_ff <= nxt_shift;
      end
   end

   // marks the first falling edge of a frame
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         first_fall_ff <= 1'b1;
      end else begin
         first_fall_ff <= 1'b0;
      end
   end

   // marks the first rising edge of a frame
   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         first_rise_ff <= 1'b1;
      end else begin
         first_rise_ff <= 1'b0;
      end
   end

   // output bit: status msb first, then the stream passes through
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         so_ff <= 1'b0;
      end else if (!cs_n) begin
         if (first_rise_ff) begin
            so_ff <= status_word[ANY_FAULT_BIT];     // [R05] [R02]
         end else begin
            so_ff <= shift_ff[WORD_W-1];             // [R02] [R10]
         end
      end
   end

   assign so_bit  = so_ff;
   assign rx_word = shift_ff;

   // ***********************************************************
   // checks
   // ***********************************************************
   property p_rx_shift;
      @(negedge sclk) disable iff (!rst_n)
      !cs_n |=> shift_ff[0] == $past(si);
   endproperty
   a_rx_shift: assert property (p_rx_shift)  // [R01]
      else $error("serial input not sampled on falling edge");

   property p_idle_hold;
      @(negedge sclk) disable iff (!rst_n)
      cs_n |=> $stable(shift_ff);
   endproperty
   a_idle_hold: assert property (p_idle_hold)  // [R03]
      else $error("shift register moved while deselected");

   property p_so_first;
      @(posedge sclk) disable iff (!rst_n || cs_n)
      first_rise_ff |=> so_ff == $past(status_word[ANY_FAULT_BIT]);
   endproperty
   a_so_first: assert property (p_so_first)  // [R05]
      else $error("first output bit is not the status msb");

   property p_so_next;
      @(posedge sclk) disable iff (!rst_n || cs_n)
      !first_rise_ff |=> so_ff == $past(shift_ff[WORD_W-1]);
   endproperty
   a_so_next: assert property (p_so_next)  // [R02]
      else $error("output bit did not advance on rising edge");

endmodule : switch_spi_link

/* logic/serial_switch_spi_slave.sv */
// serial control and fault report interface of a 16-output switch
// assumes fault and overvoltage inputs are asynchronous levels
//
// Behaviour
// [R01] sample serial input on falling shift clock
// [R02] present next status bit on rising edge
// [R03] deselected: ignore clock and data, float output
// [R04] chip select rise latches command word
// [R05] chip select fall loads fault status
// [R06] drive serial output only while selected
// [R07] master keeps clock low at select edges
// [R08] master should idle clock low
// [R09] master clock at most 6.0 MHz
// [R10] daisy chain passes data through each device
// [R11] master clocks 24 bits per device
// [R12] parallel mode uses separate chip selects
// [R13] faulted output reads one, healthy zero
// [R14] command one turns output on
// [R15] fault flagged after 100 to 450 us
// [R16] master spaces accesses over 450 us; the master model leaves only 200 ns (GAP)
// [R17] outputs respond 1 to 50 us after latch
// [R18] master gating signal at most 2.0 kHz
// [R19] both words travel msb first
// [R20] command word is 24 bits
// [R21] status layout: any, overvoltage, zeros, outputs
// [R22] odd bit count uses last 24 bits
`timescale 1ns/1ps
module serial_switch_spi_slave
   import serial_switch_pkg::*;
#(
   parameter int FLT_CYC     = FLT_CYC_DEF,
   parameter int DLY_MAX_CYC = DLY_MAX_CYC_DEF
)
(
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             sclk,
   input  wire logic             cs_n,
   input  wire logic             si,
   output logic                  so_out,
   output logic                  so_oe,
   input  wire logic [OUT_N-1:0] fault_in,
   input  wire logic             ov_in,
   output logic [OUT_N-1:0]      out_on
);

   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      logic                         cs_s1;
      logic                         cs_s2;
      logic                         cs_s3;
      logic [OUT_N-1:0]             flt_s1;
      logic [OUT_N-1:0]             flt_s2;
      logic                         ov_s1;
      logic                         ov_s2;
      logic [WORD_W-1:0]            cmd;
      logic [OUT_N-1:0]             pend;
      apply_e                       ap;
      logic [DLY_W-1:0]             dly;
      logic [OUT_N-1:0]             on;
      logic [OUT_N-1:0][FLT_W-1:0]  cnt;
      logic [OUT_N-1:0]             flt;
      logic                         ov;
      logic [WORD_W-1:0]            status;
   } sw_state_s;

   localparam logic [FLT_W-1:0] FLT_LAST = FLT_W'(FLT_CYC - 1);
   localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(DLY_APPLY_CYC - 1);

   sw_state_s         st_ff;
   sw_state_s         nxt_st;
   logic              cs_rise;
   logic [WORD_W-1:0] rx_word;
   logic              so_bit;

   // ***********************************************************
   // shift clock side
   // ***********************************************************
   switch_spi_link u_link (
      .sclk        (sclk),
      .rst_n       (rst_n),
      .cs_n        (cs_n),
      .si          (si),
      .status_word (st_ff.status),
      .so_bit      (so_bit),
      .rx_word     (rx_word)
   );

   // output driver enabled only while selected
   assign so_oe  = ~cs_n;                            // [R06] [R03]
   assign so_out = so_bit;
   assign out_on = st_ff.on;

   // end of frame as seen in the system clock domain
   assign cs_rise = st_ff.cs_s2 & ~st_ff.cs_s3;

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      nxt_st = st_ff;

      // synchronisers for chip select and analog fault levels
      nxt_st.cs_s1  = cs_n;
      nxt_st.cs_s2  = st_ff.cs_s1;
      nxt_st.cs_s3  = st_ff.cs_s2;
      nxt_st.flt_s1 = fault_in;
      nxt_st.flt_s2 = st_ff.flt_s1;
      nxt_st.ov_s1  = ov_in;
      nxt_st.ov_s2  = st_ff.ov_s1;

      // command word is stable here: clock idle, frame over
      if (cs_rise) begin
         nxt_st.cmd = rx_word;                       // [R04] [R22]
      end

      // apply sequencer: wait the response delay, then switch
      case (st_ff.ap)
         AP_IDLE: begin
            nxt_st.dly = '0;
         end
         AP_WAIT: begin
            nxt_st.dly = st_ff.dly + 1'b1;
            if (st_ff.dly == DLY_LAST) begin         // [R17]
               nxt_st.ap = AP_LOAD;
            end
         end
         AP_LOAD: begin
            nxt_st.on = st_ff.pend;                  // [R14]
            nxt_st.ap = AP_IDLE;
         end
         default: begin
            nxt_st.ap  = AP_IDLE;
            nxt_st.dly = '0;
         end
      endcase

      // a new on/off command restarts the wait with its own bits
      if (cs_rise &&
          rx_word[CMD_LSB +: CMD_W] == CMD_ONOFF) begin
         nxt_st.ap   = AP_WAIT;                      // [R04] [R17]
         nxt_st.pend = rx_word[OUT_N-1:0];           // [R14]
         nxt_st.dly = '0;
      end

      // fault persistence filter, one counter per output
      for (int i = 0; i < OUT_N; i++) begin
         if (!st_ff.flt_s2[i]) begin
            nxt_st.cnt[i] = '0;
            nxt_st.flt[i] = 1'b0;
         end else if (st_ff.cnt[i] != FLT_LAST) begin
            nxt_st.cnt[i] = st_ff.cnt[i] + 1'b1;
         end else begin
            nxt_st.flt[i] = 1'b1;                    // [R15] [R13]
         end
      end
      nxt_st.ov = st_ff.ov_s2;

      // status snapshot frozen while selected, fresh while idle
      if (st_ff.cs_s2) begin
         nxt_st.status = {st_ff.ov | (|st_ff.flt),   // [R21]
                          st_ff.ov,
                          {ZERO_W{1'b0}},
                          st_ff.flt};                // [R13]
      end
   end

   // ***********************************************************
   // registers
   // ***********************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff        <= '0;
         st_ff.cs_s1  <= 1'b1;
         st_ff.cs_s2  <= 1'b1;
         st_ff.cs_s3  <= 1'b1;
         st_ff.cmd    <= WORD_RST;
         st_ff.ap     <= AP_IDLE;
         st_ff.on     <= OUT_RST;
         st_ff.pend   <= OUT_RST;
         st_ff.status <= WORD_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************

   // end of a frame that carried an on/off command
   logic onoff_end;
   assign onoff_end = cs_rise &&
                      rx_word[CMD_LSB +: CMD_W] == CMD_ONOFF;

   // last on/off bits, kept apart from the design's own copy
   logic [OUT_N-1:0] want_on_ff;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         want_on_ff <= OUT_RST;
      end else if (onoff_end) begin
         want_on_ff <= rx_word[OUT_N-1:0];
      end
   end

   // cycles since the last on/off end of frame, saturating
   logic [SINCE_W-1:0] since_ff;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         since_ff <= '1;
      end else if (onoff_end) begin
         since_ff <= '0;
      end else if (since_ff != '1) begin
         since_ff <= since_ff + 1'b1;
      end
   end

   property p_capture;
      @(posedge sys_clk) disable iff (!rst_n)
      cs_rise |=> st_ff.cmd == $past(rx_word);
   endproperty
   a_capture: assert property (p_capture)  // [R04]
      else $error("command word not taken at chip select rise");

   property p_apply_window;
      @(posedge sys_clk) disable iff (!rst_n)
      $changed(st_ff.on) |->
         since_ff >= SINCE_W'(DLY_MIN_CYC) &&
         since_ff <= SINCE_W'(DLY_MAX_CYC);
   endproperty
   a_apply_window: assert property (p_apply_window)  // [R17]
      else $error("outputs switched outside response window");

   property p_on_value;
      @(posedge sys_clk) disable iff (!rst_n)
      $changed(st_ff.on) |-> st_ff.on == want_on_ff;
   endproperty
   a_on_value: assert property (p_on_value)  // [R14]
      else $error("outputs differ from commanded bits");

   property p_fault_persist;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(st_ff.flt[0]) |-> $past(st_ff.cnt[0]) == FLT_LAST;
   endproperty
   a_fault_persist: assert property (p_fault_persist)  // [R15]
      else $error("fault flagged before persistence time");

   property p_fault_one;
      @(posedge sys_clk) disable iff (!rst_n)
      st_ff.flt[0] |-> $past(st_ff.flt_s2[0]);
   endproperty
   a_fault_one: assert property (p_fault_one)  // [R13]
      else $error("fault reported without active condition");

   property p_status_layout;
      @(posedge sys_clk) disable iff (!rst_n)
      st_ff.status[ZERO_LSB +: ZERO_W] == '0 &&
      st_ff.status[ANY_FAULT_BIT] == (|st_ff.status[OV_BIT:0]);
   endproperty
   a_status_layout: assert property (p_status_layout)  // [R21]
      else $error("status word layout broken");

   property p_status_freeze;
      @(posedge sys_clk) disable iff (!rst_n)
      !st_ff.cs_s2 |=> $stable(st_ff.status);
   endproperty
   a_status_freeze: assert property (p_status_freeze)  // [R05]
      else $error("status changed during a frame");

   property p_oe_follow;
      @(posedge sys_clk) disable iff (!rst_n)
      so_oe |-> !cs_n;
   endproperty
   a_oe_follow: assert property (p_oe_follow)  // [R06]
      else $error("serial output driven while deselected");

   property p_cmd_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      !cs_rise |=> $stable(st_ff.cmd);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold)  // [R04]
      else $error("command word moved outside chip select rise");

   // time each synced fault has stood, saturating, one per output
   for (genvar g = 0; g < OUT_N; g++) begin : g_flt_age
      logic [FLT_W-1:0] age_ff;
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            age_ff <= '0;
         end else if (!st_ff.flt_s2[g]) begin
            age_ff <= '0;
         end else if (age_ff != '1) begin
            age_ff <= age_ff + 1'b1;
         end
      end

      property p_fault_age;
         @(posedge sys_clk) disable iff (!rst_n)
         $rose(st_ff.flt[g]) |-> age_ff == FLT_W'(FLT_CYC);
      endproperty
      a_fault_age: assert property (p_fault_age)  // [R15]
         else $error("fault bit set after wrong persistence time");
   end

endmodule : serial_switch_spi_slave

/* sim/spi_master_model.sv */
// microcontroller-side master that frames the serial switch link
// assumes the bench calls frame() one at a time; shift clock runs only
// inside a frame, or in idle_clocks, and stands low otherwise
`timescale 1ns/1ps
module spi_master_model (
   output logic      sclk,
   output logic      cs_n,
   output logic      si,
   input  wire logic so_out,
   input  wire logic so_oe
);
   // ***********************************************************
   // link timing
   // ***********************************************************
   localparam time QTR  = 42;    // quarter of a 168 ns period
   localparam time LEAD = 100;   // select fall to first data bit, QTR before first rise
   localparam time LAG  = 80;    // from a QTR after last falling edge to select rise
   localparam time GAP  = 200;   // deselected time, above 4 sys_clk

   logic so_wire;

   // level seen by the master: inverse when the device lets go
   assign so_wire = so_oe ? so_out : ~so_out;

   // the block has no gating input, so no gating signal is applied

   // idle pins: select high, clock low, data at its pull-down level
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // ***********************************************************
   // one select-low frame of nbits, msb first both ways
   // ***********************************************************
   task automatic frame(input int nbits, input logic [47:0] tx,
                        output logic [47:0] rx);
      rx = 48'h0000_0000_0000;
      #3;                           // off the system clock grid
      sclk = 1'b0;                  // clock low at select edge
      cs_n = 1'b0;                  // own select line
      #(LEAD);
      // one bit per clock, nbits is 24 per chained device
      for (int i = nbits - 1; i >= 0; i--) begin
         si = tx[i];                // msb first
         #(QTR);
         sclk = 1'b1;
         #(2 * QTR);
         rx   = {rx[46:0], so_wire};
         sclk = 1'b0;
         #(QTR);
      end
      #(LAG);
      cs_n = 1'b1;                  // clock still low here
      si   = 1'b0;                  // released, pull-down wins
      #(GAP);                       // spacing between accesses
   endtask : frame

   // clock pulses while deselected: allowed, though not advised
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         si = ~si;
         #(QTR);
         sclk = 1'b1;
         #(2 * QTR);
         sclk = 1'b0;               // ends low before any select edge
         #(QTR);
      end
      si = 1'b0;
   endtask : idle_clocks

endmodule : spi_master_model

/* sim/tb_top.sv */
// self-checking bench for the serial switch control interface
// assumes the master model owns sclk, cs_n and si
`timescale 1ns/1ps
module tb_top;
   import serial_switch_pkg::*;

   localparam int FLT = 20;       // shortened fault persistence
   localparam int LIM = 6250;     // latest response in cycles

   logic             sys_clk;
   logic             rst_n;
   logic             sclk;
   logic             cs_n;
   logic             si;
   logic             so_out;
   logic             so_oe;
   logic             ov_in;
   logic [OUT_N-1:0] fault_in;
   logic [OUT_N-1:0] out_on;
   logic [47:0]      rx;
   int               miscompares;
   int               n_tests;

   serial_switch_spi_slave #(.FLT_CYC(FLT), .DLY_MAX_CYC(LIM))
      i_serial_switch_spi_slave (
      .sys_clk (sys_clk), .rst_n (rst_n), .sclk (sclk), .cs_n (cs_n),
      .si (si), .so_out (so_out), .so_oe (so_oe), .fault_in (fault_in),
      .ov_in (ov_in), .out_on (out_on));

   spi_master_model i_spi_master_model (
      .sclk (sclk), .cs_n (cs_n), .si (si), .so_out (so_out),
      .so_oe (so_oe));

   // 125 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ***********************************************************
   // shared helpers
   // ***********************************************************
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [47:0] got, input logic [47:0] exp,
                        input string what);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // waits for the outputs to take exp and judges the delay
   task automatic wait_out(input logic [15:0] exp);
      int n;
      n = 0;
      while (out_on !== exp && n < LIM) begin
         @(negedge sys_clk);
         n++;
      end
      check(48'(n >= DLY_MIN_CYC && n < LIM), 48'h1, "delay");
      check(48'(out_on), 48'(exp), "outputs");
      if (n >= LIM) begin
         final_report();
      end
   endtask : wait_out

   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_reset;
      check(48'(out_on), 48'h0, "reset outputs");
      check(48'(so_oe), 48'h0, "float when deselected");
   endtask : t_reset

   task automatic t_onoff;
      i_spi_master_model.frame(24, 48'h0000_0000_A5C3, rx);
      check(rx[23:0], 48'h0, "clean status");
      wait_out(16'hA5C3);
      check(48'(so_oe), 48'h0, "float after frame");
   endtask : t_onoff

   task automatic t_refuse;
      i_spi_master_model.frame(24, 48'h0000_0004_FFFF, rx);
      repeat (2000) @(negedge sys_clk);
      check(48'(out_on), 48'hA5C3, "other command kept");
      // a refused word during the wait keeps the pending on/off bits
      i_spi_master_model.frame(24, 48'h0000_0000_5A5A, rx);
      i_spi_master_model.frame(24, 48'h0000_0004_FFFF, rx);
      wait_out(16'h5A5A);
   endtask : t_refuse

   task automatic t_fault;
      @(negedge sys_clk);
      fault_in = 16'h8001;
      ov_in    = 1'b1;
      repeat (10) @(negedge sys_clk);
      i_spi_master_model.frame(24, 48'h0000_0000_A5C3, rx);
      check(rx[23:0], 48'hC0_0000, "fault too young");
      repeat (2 * FLT) @(negedge sys_clk); // spaced past persistence
      i_spi_master_model.frame(24, 48'h0000_0000_A5C3, rx);
      check(rx[23:0], 48'hC0_8001, "fault status");
      @(negedge sys_clk);
      fault_in = 16'h0000;
      ov_in    = 1'b0;
      repeat (10) @(negedge sys_clk);
   endtask : t_fault

   task automatic t_daisy;
      i_spi_master_model.frame(48, {24'h00_0F0F, 24'h00_3C3C}, rx);
      check(rx[47:24], 48'h0, "chain status");
      check(rx[23:0], 48'h00_0F0F, "chain echo");
      wait_out(16'h3C3C);
   endtask : t_daisy

   task automatic t_partial;
      i_spi_master_model.frame(30, {18'h0_0000, 6'h3F, 24'h00_1234}, rx);
      check(rx[29:6], 48'h0, "partial status");
      check(rx[5:0], 48'h3F, "partial echo");
      wait_out(16'h1234);
   endtask : t_partial

   task automatic t_idle;
      i_spi_master_model.idle_clocks(30);
      repeat (20) @(negedge sys_clk);
      check(48'(out_on), 48'h1234, "deselected clocks ignored");
      check(48'(so_oe), 48'h0, "float during idle clocks");
      i_spi_master_model.frame(24, 48'h0000_0000_00FF, rx);
      check(rx[23:0], 48'h0, "status after idle clocks");
      wait_out(16'h00FF);
   endtask : t_idle

   task automatic t_midreset;
      @(negedge sys_clk);
      rst_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(48'(out_on), 48'h0, "outputs off in reset");
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      check(48'(out_on), 48'h0, "outputs off after reset");
   endtask : t_midreset

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      miscompares = 0;
      n_tests     = 0;
      rst_n       = 1'b0;
      fault_in    = 16'h0000;
      ov_in       = 1'b0;
      repeat (16) @(negedge sys_clk);
      t_reset();
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_onoff();
      t_refuse();
      t_fault();
      t_daisy();
      t_partial();
      t_idle();
      t_midreset();
      final_report();
   end

   // cuts a hang short
   initial begin
      #400us;
      miscompares++;
      final_report();
   end

endmodule : tb_top
